// File: src/sp8_shift.sv
// Serial-in parallel-out shift register with snapshot FIFO
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module sp8_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic space_r;
    logic out_valid_r;
    logic [WIDTH-1:0] out_data_r;
    wire push = in_valid & space_r;
    wire pop = (cnt_r != '0) & (~out_valid_r | out_ready);

    assign cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    assign in_ready = space_r;
    assign out_valid = out_valid_r;
    assign out_data = out_data_r;

    // Storage has no reset, so it maps onto plain RAM
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
            space_r <= 1'b1;
        end else begin
            wr_ptr_r <= push ? wr_ptr_r + AW'(1) : wr_ptr_r;
            rd_ptr_r <= pop ? rd_ptr_r + AW'(1) : rd_ptr_r;
            cnt_r <= cnt_nxt;
            space_r <= (cnt_nxt != CW'(DEPTH));
        end
    end

    // Registered head keeps drain outputs straight from flops
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            out_valid_r <= 1'b0;
            out_data_r <= '0;
        end else if (pop) begin
            out_valid_r <= 1'b1;
            out_data_r <= mem[rd_ptr_r];
        end else if (out_ready) begin
            out_valid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    AST_HEAD_HOLD: assert property (@(posedge core_clk) disable iff (reset)
        (out_valid_r && !out_ready) |=> out_valid_r && $stable(out_data_r))
        else $error("snapshot head changed while waiting");

    AST_NO_OVERFILL: assert property (@(posedge core_clk) disable iff (reset)
        cnt_r <= CW'(DEPTH))
        else $error("snapshot fifo count above depth");
endmodule

////////////////////////////////////////////////////////////////////////////////
module sp8_shift
    import sp8_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Pins from the driving logic
    input wire logic serial_in_a,
    input wire logic serial_in_b,
    input wire logic shift_clock,
    input wire logic master_clear_n,
    // Parallel stage outputs
    output logic stage_out_first,
    output logic [STAGES-2:0] stage_out_rest,
    // Snapshot stream
    output logic snap_valid,
    input wire logic snap_ready,
    output logic [STAGES-1:0] snap_data,
    output logic capture_ready
);
    logic [PIN_COUNT-1:0] pin_s1_r;
    logic [PIN_COUNT-1:0] pin_s2_r;
    logic [PIN_COUNT-1:0] pin_s3_r;
    logic [PIN_COUNT-1:0] pin_filt_r;
    logic [PIN_COUNT-1:0] pin_filt_nxt;
    logic [PIN_COUNT-1:0] pin_agree;
    logic [STAGES-1:0] stage_r;
    logic [STAGES-1:0] stage_nxt;
    logic push_r;

    ////////////////////////////////////////////////////////////////////////////
    // Three-flop pin sampling; first flop feeds only the second
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pin_s1_r <= PIN_RESET;
            pin_s2_r <= PIN_RESET;
            pin_s3_r <= PIN_RESET;
            pin_filt_r <= PIN_RESET;
        end else begin
            pin_s1_r <= {shift_clock, serial_in_a, serial_in_b};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_filt_r <= pin_filt_nxt;
        end
    end

    // A pin change counts only once flops two and three agree
    assign pin_agree = ~(pin_s2_r ^ pin_s3_r);
    assign pin_filt_nxt = (pin_agree & pin_s3_r) | (~pin_agree & pin_filt_r);

    // Rising edge only; falling edge is ignored
    wire shift_evt = pin_agree[PIN_CLK] & pin_s3_r[PIN_CLK] & ~pin_filt_r[PIN_CLK];
    // Settled data level from before the edge, for setup margin
    wire data_a = pin_filt_r[PIN_A];
    wire data_b = pin_filt_r[PIN_B];
    // Either input acts as data enable
    wire first_in = data_a & data_b;
    // Clear is asynchronous, so stages drop without a clock
    wire stage_clr = reset | ~master_clear_n;

    ////////////////////////////////////////////////////////////////////////////
    // Shift chain
    assign stage_nxt = shift_evt ? {stage_r[STAGES-2:0], first_in} : stage_r;

    // Clear sits in the async branch, so it outranks any edge
    always_ff @(posedge core_clk or posedge stage_clr) begin
        if (stage_clr) begin
            stage_r <= STAGE_RESET;
            push_r <= 1'b0;
        end else begin
            stage_r <= stage_nxt;
            push_r <= shift_evt;
        end
    end

    // Outputs are the stage flops themselves
    assign stage_out_first = stage_r[0];
    assign stage_out_rest = stage_r[STAGES-1:1];

    ////////////////////////////////////////////////////////////////////////////
    // Snapshot FIFO; a word is dropped when full since shifting never stalls
    sp8_fifo #(
        .WIDTH(STAGES),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .reset(reset),
        .in_valid(push_r),
        .in_ready(capture_ready),
        .in_data(stage_r),
        .out_valid(snap_valid),
        .out_ready(snap_ready),
        .out_data(snap_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    AST_CLEAR_LOW: assert property (@(posedge core_clk) disable iff (reset)
        !master_clear_n |-> (stage_out_first == 1'b0) && (stage_out_rest == '0))
        else $error("stages not low while clear is active");

    AST_CLEAR_WINS: assert property (@(posedge core_clk) disable iff (reset)
        (shift_evt && !master_clear_n) ##1 !master_clear_n |-> stage_r == STAGE_RESET)
        else $error("clock edge overrode active clear");

    AST_SHIFT_MOVE: assert property (@(posedge core_clk) disable iff (reset)
        (shift_evt && master_clear_n) ##1 master_clear_n |->
        stage_r[STAGES-1:1] == $past(stage_r[STAGES-2:0]))
        else $error("stages did not move up by one");

    AST_FIRST_AND: assert property (@(posedge core_clk) disable iff (reset)
        (shift_evt && master_clear_n) ##1 master_clear_n |->
        stage_r[0] == ($past(data_a) & $past(data_b)))
        else $error("first stage is not AND of serial inputs");

    AST_HOLD: assert property (@(posedge core_clk) disable iff (reset)
        (!shift_evt && master_clear_n) ##1 master_clear_n |-> $stable(stage_r))
        else $error("stages changed without rising shift edge");

    AST_EDGE_ONCE: assert property (@(posedge core_clk) disable iff (reset)
        shift_evt |=> !shift_evt)
        else $error("one shift edge counted twice");

    AST_SNAPSHOT: assert property (@(posedge core_clk) disable iff (reset)
        (shift_evt && master_clear_n) ##1 master_clear_n |-> push_r)
        else $error("shift not offered to snapshot fifo");

    AST_CLEAR_NO_PUSH: assert property (@(posedge core_clk) disable iff (reset)
        !master_clear_n |-> !push_r)
        else $error("snapshot offered while clear is active");
endmodule

// File: src/sp8_pkg.sv
// Package of shared constants for the serial-in parallel-out shift register
package sp8_pkg;
    localparam int STAGES = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int PIN_COUNT = 3;
    localparam int PIN_CLK = 2;
    localparam int PIN_A = 1;
    localparam int PIN_B = 0;
    localparam logic [STAGES-1:0] STAGE_RESET = 8'h00;
    localparam logic [PIN_COUNT-1:0] PIN_RESET = 3'h0;
endpackage

// File: sim/sp8_drv.sv
// Driving logic model: serial data, shift clock and clear
`timescale 1ns/1ps
module sp8_drv (
    // Clock
    input wire logic core_clk,
    // Pins toward the register
    output logic ser_a,
    output logic ser_b,
    output logic shclk,
    output logic clr_n
);
    initial begin
        {ser_a, ser_b, shclk, clr_n} = 4'h1;
    end
    // Data set 2 cycles early, held past the rise for setup and hold
    task automatic shift(input logic va, input logic vb);
        @(posedge core_clk) #1 {ser_a, ser_b} = {va, vb};
        repeat (2) @(posedge core_clk);
        #1 shclk = 1'h1;
        repeat (3) @(posedge core_clk);
        #1 shclk = 1'h0;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic clear(input logic v);
        @(posedge core_clk) #1 clr_n = v;
    endtask
endmodule

// File: sim/sp8_shift_tb_top.sv
// Testbench for the shift register and its snapshot stream
`timescale 1ns/1ps
module sp8_shift_tb_top;
    import sp8_pkg::*;
    logic core_clk, reset, snap_ready, ser_a, ser_b, shclk, clr_n;
    logic s_first, snap_valid, capture_ready;
    logic [STAGES-2:0] s_rest;
    logic [STAGES-1:0] snap_data, exp_stg;
    logic [STAGES-1:0] exp_q[$];
    int err_count, cmp_count, cyc;
    sp8_drv DRV (.core_clk(core_clk), .ser_a(ser_a), .ser_b(ser_b), .shclk(shclk), .clr_n(clr_n));
    sp8_shift DUT (.core_clk(core_clk), .reset(reset), .serial_in_a(ser_a), .serial_in_b(ser_b),
        .shift_clock(shclk), .master_clear_n(clr_n), .stage_out_first(s_first), .stage_out_rest(s_rest),
        .snap_valid(snap_valid), .snap_ready(snap_ready), .snap_data(snap_data),
        .capture_ready(capture_ready));
    initial begin
        core_clk = 1'h0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done();
        if (err_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Fifo plus head hold 33; queued first, as the word may surface as shift returns
    task automatic do_shift(input logic va, input logic vb);
        exp_stg = {exp_stg[6:0], va & vb};
        if (exp_q.size() < FIFO_DEPTH + 1) exp_q.push_back(exp_stg);
        DRV.shift(va, vb);
        chk("stages", exp_stg, {s_rest, s_first});
    endtask
    task automatic t_gates();
        for (int i = 0; i < 11; i++) do_shift(i[0], i[1] | i[3]);
    endtask
    task automatic t_clear();
        DRV.clear(1'h0);
        #2 chk("clear", 8'h00, {s_rest, s_first});
        DRV.shift(1'h1, 1'h1);
        chk("clr_edge", 8'h00, {s_rest, s_first});
        DRV.clear(1'h1);
        exp_stg = 8'h00;
        do_shift(1'h1, 1'h1);
    endtask
    task automatic t_fill();
        @(posedge core_clk) #1 snap_ready = 1'h0;
        for (int i = 0; i < 36; i++) do_shift(i % 3 != 0, 1'h1);
        chk("full", 8'h00, {7'h0, capture_ready});
        @(posedge core_clk) #1 snap_ready = 1'h1;
        for (int k = 0; k < 300 && exp_q.size() > 0; k++) @(posedge core_clk);
        repeat (3) @(posedge core_clk);
        chk("drained", 8'h01, {6'h0, snap_valid, capture_ready});
    endtask
    // Sampled at the edge, before the design's updates land
    always @(posedge core_clk) begin
        cyc++;
        if (snap_valid === 1'h1 && snap_ready === 1'h1) begin
            if (exp_q.size() == 0) chk("extra", 8'h00, 8'hFF);
            else chk("snap", exp_q.pop_front(), snap_data);
        end
        if (cyc == 3000) begin
            err_count++;
            test_done();
        end
    end
    initial begin
        {reset, snap_ready, exp_stg} = {1'h1, 1'h1, 8'h00};
        repeat (10) @(posedge core_clk);
        #1 reset = 1'h0;
        chk("rst", 8'h00, {s_rest, s_first});
        chk("rst_fl", 8'h01, {6'h0, snap_valid, capture_ready});
        t_gates();
        t_clear();
        t_fill();
        test_done();
    end
endmodule
